// file: rtl/vstac_ctrl.sv
`timescale 1ns/1ns
`include "vstac_defines.svh"
module vstac_ctrl #(
    parameter int ADC_W = 8,
    parameter logic [ADC_W-1:0] ADC_TOP = 8'hd6,
    parameter logic [ADC_W-1:0] ADC_STEP = 8'h0a
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire vstac_pkg::vstac_bus_t avs_req,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire vstac_pkg::vstac_req_t cmd_primary,
    input wire vstac_pkg::vstac_req_t cmd_graphics,
    output logic [7:0] target_voltage_code_primary,
    output logic [7:0] target_voltage_code_graphics,
    output logic continuous_conduction_primary,
    output logic continuous_conduction_graphics,
    output logic diode_emulation_primary,
    output logic diode_emulation_graphics,
    output logic alert_n_o,
    output logic alert_n_oe,
    output logic thermal_throttle_n,
    output logic bias_primary_sel,
    output logic bias_graphics_sel,
    input wire logic adc_valid,
    input wire logic [ADC_W-1:0] adc_data,
    input wire logic multi_phase,
    output logic aux_switch_close,
    output logic aux_track_drive,
    input wire logic discontinuous_conduction,
    input wire logic low_side_on_req,
    input wire logic zero_cross_pin,
    input wire logic body_diode_pin,
    output logic low_side_gate,
    output logic [5:0] zero_threshold
);
    localparam int FAST_TICKS = (`VSTAC_CLK_HZ / 1000000) * `VSTAC_STEP_UV / `VSTAC_FAST_UV_PER_US;
    localparam int SLOW_TICKS = (`VSTAC_CLK_HZ / 1000000) * `VSTAC_STEP_UV / `VSTAC_SLOW_UV_PER_US;
    localparam int HALF_NTC = `VSTAC_CLK_HZ / (2 * `VSTAC_NTC_HZ);
    localparam int DIODE_CYC = (`VSTAC_DIODE_NS + `VSTAC_CLK_NS - 1) / `VSTAC_CLK_NS;

    typedef struct packed {
        vstac_pkg::vstac_rail_t [1:0] rail;
        logic [7:0] zone_p;
        logic [7:0] zone_g;
        logic [7:0] status1;
        logic alert;
        logic hot;
        logic [7:0] ntc_cnt;
        logic ntc_side;
        logic adc_side;
        logic [1:0] zc_sync;
        logic [1:0] bd_sync;
        logic ls_gate;
        logic ls_was;
        logic [3:0] bd_cnt;
        logic bd_watch;
        logic [5:0] thresh;
        logic [31:0] rdata;
        logic rdone;
        logic adapt_en;
    } vstac_state_t;

    vstac_state_t s_q, s_d;

    // Thermometer code: one more bit per ADC step below the top reading
    function automatic logic [7:0] zone_of(input logic [ADC_W-1:0] v);
        logic [7:0] z;
        z = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (int'(v) <= int'(ADC_TOP) - i * int'(ADC_STEP)) begin
                z[i] = 1'b1;
            end
        end
        return z;
    endfunction

    function automatic vstac_pkg::vstac_rail_t rail_step(input vstac_pkg::vstac_rail_t r,
                                                         input vstac_pkg::vstac_req_t c,
                                                         output logic done_alert);
        vstac_pkg::vstac_rail_t n;
        n = r;
        done_alert = 1'b0;
        if (c.valid && c.kind != vstac_pkg::vstac_cmd_none) begin
            n.kind = c.kind;
            n.target = c.code;
            n.tick = 12'h000;
            if (c.kind == vstac_pkg::vstac_cmd_decay) begin
                n.mode = vstac_pkg::vstac_decay;
            end else begin
                // Reversal out of a pending decay is immediate
                if (r.mode == vstac_pkg::vstac_decay && c.code > r.level) begin
                    done_alert = 1'b1;
                end
                n.mode = vstac_pkg::vstac_ramp;
            end
        end else if (r.mode != vstac_pkg::vstac_idle) begin
            if (r.level == r.target) begin
                if (r.mode == vstac_pkg::vstac_ramp) begin
                    done_alert = 1'b1;
                end
                n.mode = vstac_pkg::vstac_idle;
            end else if ((r.kind == vstac_pkg::vstac_cmd_slow && int'(r.tick) >= SLOW_TICKS - 1) ||
                         (r.kind != vstac_pkg::vstac_cmd_slow && int'(r.tick) >= FAST_TICKS - 1)) begin
                // Decay descent also uses the fast tick as its limit
                n.tick = 12'h000;
                n.level = (r.level < r.target) ? r.level + 8'h01 : r.level - 8'h01;
            end else begin
                n.tick = r.tick + 12'h001;
            end
        end
        return n;
    endfunction

    logic [1:0] rail_alert;
    logic [7:0] new_zone;
    logic [7:0] old_zone;

    always_comb begin
        s_d = s_q;
        rail_alert = 2'b00;
        new_zone = 8'h00;
        old_zone = 8'h00;
        s_d.rail[0] = rail_step(s_q.rail[0], cmd_primary, rail_alert[0]);
        s_d.rail[1] = rail_step(s_q.rail[1], cmd_graphics, rail_alert[1]);

        // Bias alternation divider
        if (int'(s_q.ntc_cnt) >= HALF_NTC - 1) begin
            s_d.ntc_cnt = 8'h00;
            s_d.ntc_side = ~s_q.ntc_side;
        end else begin
            s_d.ntc_cnt = s_q.ntc_cnt + 8'h01;
        end

        // A sample arrives one cycle after launch; credit it to the pin biased then
        s_d.adc_side = s_q.ntc_side;
        if (adc_valid) begin
            new_zone = zone_of(adc_data);
            old_zone = s_q.adc_side ? s_q.zone_g : s_q.zone_p;
            if (s_q.adc_side) begin
                s_d.zone_g = new_zone;
            end else begin
                s_d.zone_p = new_zone;
            end
        end

        // Bus: read data is prepared in the first cycle, the transfer is taken in the second
        s_d.rdone = 1'b0;
        if ((avs_req.read || avs_req.write) && !s_q.rdone) begin
            s_d.rdone = 1'b1;
            s_d.rdata = 32'h0000_0000;
            case (avs_req.address)
                `VSTAC_ADDR_STATUS1: begin
                    s_d.rdata = {24'h000000, s_q.status1};
                end
                `VSTAC_ADDR_ZONE: begin
                    s_d.rdata = {24'h000000, s_q.zone_p | s_q.zone_g};
                end
                `VSTAC_ADDR_TARGET0: begin
                    s_d.rdata = {24'h000000, s_q.rail[0].level};
                end
                `VSTAC_ADDR_TARGET1: begin
                    s_d.rdata = {24'h000000, s_q.rail[1].level};
                end
                `VSTAC_ADDR_CTRL: begin
                    s_d.rdata = {31'h0, s_q.adapt_en};
                end
                `VSTAC_ADDR_ZERO_TH: begin
                    s_d.rdata = {26'h0, s_q.thresh};
                end
                default: begin
                    s_d.rdata = 32'h0000_0000;
                end
            endcase
        end
        // Side effects land only at the edge where waitrequest is low
        if (avs_req.write && s_q.rdone && avs_req.address == `VSTAC_ADDR_CTRL) begin
            s_d.adapt_en = avs_req.writedata[0];
        end
        if (avs_req.read && s_q.rdone && avs_req.address == `VSTAC_ADDR_STATUS1) begin
            s_d.alert = 1'b0;
            // Only a settle flag that was reported is cleared
            if (s_q.rdata[`VSTAC_ST1_SETTLE_BIT]) begin
                s_d.status1[`VSTAC_ST1_SETTLE_BIT] = 1'b0;
            end
        end

        // Thermal edges; setting the alert wins over a clearing read
        if (adc_valid) begin
            if (!old_zone[`VSTAC_ZONE_ALERT_BIT] && new_zone[`VSTAC_ZONE_ALERT_BIT]) begin
                s_d.status1[`VSTAC_ST1_THERM_BIT] = 1'b1;
                s_d.alert = 1'b1;
            end
            if (old_zone[`VSTAC_ZONE_CLR_BIT] && !new_zone[`VSTAC_ZONE_CLR_BIT]) begin
                s_d.status1[`VSTAC_ST1_THERM_BIT] = 1'b0;
                s_d.alert = 1'b1;
            end
            if (!old_zone[`VSTAC_ZONE_HOT_BIT] && new_zone[`VSTAC_ZONE_HOT_BIT]) begin
                s_d.hot = 1'b1;
            end else if (old_zone[`VSTAC_ZONE_ALERT_BIT] && !new_zone[`VSTAC_ZONE_ALERT_BIT]) begin
                s_d.hot = 1'b0;
            end
        end
        // Sets come after the clearing read, so a set in the same cycle wins
        if (rail_alert != 2'b00) begin
            s_d.status1[`VSTAC_ST1_SETTLE_BIT] = 1'b1;
            s_d.alert = 1'b1;
        end

        // Zero-cross turn-off and adaptive threshold
        s_d.zc_sync = {s_q.zc_sync[0], zero_cross_pin};
        s_d.bd_sync = {s_q.bd_sync[0], body_diode_pin};
        s_d.ls_was = s_q.ls_gate;
        if (!discontinuous_conduction) begin
            s_d.ls_gate = low_side_on_req;
        end else if (s_q.zc_sync[1]) begin
            s_d.ls_gate = 1'b0;
        end else begin
            s_d.ls_gate = low_side_on_req;
        end
        if (s_q.ls_was && !s_q.ls_gate && discontinuous_conduction) begin
            s_d.bd_watch = 1'b1;
            s_d.bd_cnt = 4'h0;
        end else if (s_q.bd_watch) begin
            if (s_q.bd_sync[1] && s_q.bd_cnt != 4'hf) begin
                s_d.bd_cnt = s_q.bd_cnt + 4'h1;
            end else begin
                s_d.bd_watch = 1'b0;
                if (s_q.adapt_en) begin
                    // Longer conduction: switch off earlier by raising threshold
                    if (int'(s_q.bd_cnt) > DIODE_CYC && s_q.thresh != `VSTAC_TH_MAX) begin
                        s_d.thresh = s_q.thresh + 6'h01;
                    end else if (int'(s_q.bd_cnt) < DIODE_CYC && s_q.thresh != 6'h00) begin
                        s_d.thresh = s_q.thresh - 6'h01;
                    end
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.thresh <= `VSTAC_TH_RESET;
            s_q.zone_p <= `VSTAC_ZONE_RESET;
            s_q.zone_g <= `VSTAC_ZONE_RESET;
            s_q.adapt_en <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_waitrequest = (avs_req.read || avs_req.write) && !s_q.rdone;
    assign avs_readdata = s_q.rdata;
    assign target_voltage_code_primary = s_q.rail[0].level;
    assign target_voltage_code_graphics = s_q.rail[1].level;
    assign continuous_conduction_primary = s_q.rail[0].mode != vstac_pkg::vstac_decay;
    assign continuous_conduction_graphics = s_q.rail[1].mode != vstac_pkg::vstac_decay;
    assign diode_emulation_primary = s_q.rail[0].mode == vstac_pkg::vstac_decay;
    assign diode_emulation_graphics = s_q.rail[1].mode == vstac_pkg::vstac_decay;
    assign alert_n_o = 1'b0;
    assign alert_n_oe = s_q.alert;
    assign thermal_throttle_n = ~s_q.hot;
    assign bias_primary_sel = ~s_q.ntc_side;
    assign bias_graphics_sel = s_q.ntc_side;
    assign aux_switch_close = multi_phase;
    assign aux_track_drive = ~multi_phase;
    assign low_side_gate = s_q.ls_gate;
    assign zero_threshold = s_q.thresh;
endmodule

// file: rtl/vstac_defines.svh
`ifndef VSTAC_DEFINES_SVH
`define VSTAC_DEFINES_SVH
`define VSTAC_CLK_HZ 10000000
`define VSTAC_STEP_UV 5000
`define VSTAC_FAST_UV_PER_US 10000
`define VSTAC_SLOW_UV_PER_US 2500
`define VSTAC_NTC_HZ 36000
`define VSTAC_DIODE_NS 40
`define VSTAC_CLK_NS 100
`define VSTAC_IDX_STATUS1 8'h10
`define VSTAC_IDX_ZONE 8'h12
`define VSTAC_ADDR_STATUS1 8'h40
`define VSTAC_ADDR_ZONE 8'h48
`define VSTAC_ADDR_TARGET0 8'h80
`define VSTAC_ADDR_TARGET1 8'h84
`define VSTAC_ADDR_CTRL 8'h88
`define VSTAC_ADDR_ZERO_TH 8'h8c
`define VSTAC_ST1_THERM_BIT 1
`define VSTAC_ST1_SETTLE_BIT 0
`define VSTAC_ZONE_ALERT_BIT 6
`define VSTAC_ZONE_HOT_BIT 7
`define VSTAC_ZONE_CLR_BIT 5
`define VSTAC_ZONE_RESET 8'h00
`define VSTAC_TH_RESET 6'h20
`define VSTAC_TH_MAX 6'h3f
`endif

// file: rtl/vstac_pkg.sv
package vstac_pkg;
    typedef enum logic [1:0] {vstac_cmd_none, vstac_cmd_fast, vstac_cmd_slow, vstac_cmd_decay} vstac_cmd_t;
    typedef enum logic [1:0] {vstac_idle, vstac_ramp, vstac_decay} vstac_mode_t;
    typedef struct packed {
        logic valid;
        vstac_cmd_t kind;
        logic [7:0] code;
    } vstac_req_t;
    typedef struct packed {
        logic [7:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } vstac_bus_t;
    typedef struct packed {
        vstac_mode_t mode;
        vstac_cmd_t kind;
        logic [7:0] target;
        logic [7:0] level;
        logic [11:0] tick;
    } vstac_rail_t;
endpackage

// file: test/vstac_ctrl_assertions.sv
`timescale 1ns/1ns
module vstac_ctrl_assertions (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire vstac_pkg::vstac_bus_t avs_req,
    input wire logic avs_waitrequest,
    input wire vstac_pkg::vstac_req_t cmd_primary,
    input wire logic [7:0] target_voltage_code_primary,
    input wire logic continuous_conduction_primary,
    input wire logic diode_emulation_primary,
    input wire logic alert_n_oe,
    input wire logic thermal_throttle_n,
    input wire logic bias_primary_sel,
    input wire logic bias_graphics_sel,
    input wire logic adc_valid,
    input wire logic multi_phase,
    input wire logic aux_switch_close,
    input wire logic aux_track_drive
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    sequence bus_answer;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    sequence decay_cmd;
        cmd_primary.valid && cmd_primary.kind == vstac_pkg::vstac_cmd_decay;
    endsequence
    // Fast and slow are the two kinds whose code bits differ
    sequence ramp_cmd;
        cmd_primary.valid && (^cmd_primary.kind);
    endsequence
    bus_wait_a: assert property ($rose(avs_req.read || avs_req.write) |-> bus_answer)
        else $error("bus answer timing");
    decay_mode_a: assert property (decay_cmd |=> diode_emulation_primary && !continuous_conduction_primary)
        else $error("decay not in diode emulation");
    ramp_mode_a: assert property (ramp_cmd |=> continuous_conduction_primary && !diode_emulation_primary)
        else $error("ramp not continuous");
    ramp_step_a: assert property ($changed(target_voltage_code_primary) |->
        (target_voltage_code_primary - $past(target_voltage_code_primary) == 8'h01) ||
        ($past(target_voltage_code_primary) - target_voltage_code_primary == 8'h01)) else $error("level jumped");
    hot_cause_a: assert property ($changed(thermal_throttle_n) |-> $past(adc_valid))
        else $error("throttle moved without sample");
    alert_release_a: assert property ($fell(alert_n_oe) |->
        $past(avs_req.read && !avs_waitrequest && avs_req.address == 8'h40)) else $error("alert released early");
    bias_pair_a: assert property (bias_primary_sel != bias_graphics_sel)
        else $error("bias not complementary");
    bias_rate_a: assert property ($changed(bias_primary_sel) |-> ##138 $changed(bias_primary_sel))
        else $error("bias period");
    aux_switch_a: assert property (aux_switch_close == multi_phase && aux_track_drive == !multi_phase)
        else $error("aux switch state");
endmodule
bind vstac_ctrl vstac_ctrl_assertions chk (.sys_clk, .rstn, .avs_req, .avs_waitrequest, .cmd_primary,
    .target_voltage_code_primary, .continuous_conduction_primary, .diode_emulation_primary, .alert_n_oe,
    .thermal_throttle_n, .bias_primary_sel, .bias_graphics_sel, .adc_valid, .multi_phase, .aux_switch_close,
    .aux_track_drive);

// file: test/vstac_far_model.sv
`timescale 1ns/1ns
module vstac_far_model (
    input wire logic sys_clk,
    input wire logic avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    input wire logic bias_graphics_sel,
    output vstac_pkg::vstac_bus_t avs_req = '0,
    output vstac_pkg::vstac_req_t cmd_primary = '0,
    output vstac_pkg::vstac_req_t cmd_graphics = '0,
    output logic adc_valid = 1'b0,
    output logic [7:0] adc_data = 8'hff
);
    logic [7:0] temp_p = 8'hff;
    logic [7:0] temp_g = 8'hff;
    logic [3:0] div_q = 4'h0;
    // Converts whichever pin is biased now; data is junk between samples
    always @(posedge sys_clk) begin
        div_q <= div_q + 4'h1;
        adc_valid <= div_q == 4'hf;
        adc_data <= (div_q == 4'hf) ? (bias_graphics_sel ? temp_g : temp_p) : {div_q, ~div_q};
    end
    task automatic access(input logic [7:0] a, input logic we, input logic [31:0] wd, output logic [31:0] rd,
        output bit ok);
        @(posedge sys_clk);
        avs_req <= {a, !we, we, wd};
        ok = 1'b0;
        for (int n = 0; n < 50 && !ok; n++) begin
            @(posedge sys_clk);
            ok = avs_waitrequest === 1'b0;
        end
        rd = avs_readdata;
        avs_req <= {~a, 2'h0, ~wd};
    endtask
    task automatic cmd(input bit gfx, input logic [1:0] k, input logic [7:0] code);
        @(posedge sys_clk);
        if (gfx) cmd_graphics <= {1'b1, vstac_pkg::vstac_cmd_t'(k), code};
        else cmd_primary <= {1'b1, vstac_pkg::vstac_cmd_t'(k), code};
        @(posedge sys_clk);
        cmd_graphics <= {1'b0, ~code[1:0], ~code};
        cmd_primary <= {1'b0, ~code[1:0], ~code};
        #1;
    endtask
endmodule

// file: test/vid_slew_thermal_alert_ctrl_test.sv
`timescale 1ns/1ns
module vid_slew_thermal_alert_ctrl_test;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic multi_phase = 1'b1;
    logic discontinuous_conduction = 1'b0;
    logic low_side_on_req = 1'b0;
    logic zero_cross_pin = 1'b0;
    logic body_diode_pin = 1'b0;
    vstac_pkg::vstac_bus_t avs_req;
    vstac_pkg::vstac_req_t cmd_primary, cmd_graphics;
    logic [31:0] avs_readdata, rv;
    logic avs_waitrequest, continuous_conduction_primary, continuous_conduction_graphics;
    logic diode_emulation_primary, diode_emulation_graphics, alert_n_o, alert_n_oe, thermal_throttle_n;
    logic bias_primary_sel, bias_graphics_sel, adc_valid, aux_switch_close, aux_track_drive, low_side_gate;
    logic [7:0] target_voltage_code_primary, target_voltage_code_graphics, adc_data;
    logic [5:0] zero_threshold;
    int num_errors = 0;
    int check_count = 0;
    always #50 sys_clk = ~sys_clk;
    vstac_ctrl dut (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .avs_req(avs_req),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .cmd_primary(cmd_primary),
        .cmd_graphics(cmd_graphics),
        .target_voltage_code_primary(target_voltage_code_primary),
        .target_voltage_code_graphics(target_voltage_code_graphics),
        .continuous_conduction_primary(continuous_conduction_primary),
        .continuous_conduction_graphics(continuous_conduction_graphics),
        .diode_emulation_primary(diode_emulation_primary),
        .diode_emulation_graphics(diode_emulation_graphics),
        .alert_n_o(alert_n_o),
        .alert_n_oe(alert_n_oe),
        .thermal_throttle_n(thermal_throttle_n),
        .bias_primary_sel(bias_primary_sel),
        .bias_graphics_sel(bias_graphics_sel),
        .adc_valid(adc_valid),
        .adc_data(adc_data),
        .multi_phase(multi_phase),
        .aux_switch_close(aux_switch_close),
        .aux_track_drive(aux_track_drive),
        .discontinuous_conduction(discontinuous_conduction),
        .low_side_on_req(low_side_on_req),
        .zero_cross_pin(zero_cross_pin),
        .body_diode_pin(body_diode_pin),
        .low_side_gate(low_side_gate),
        .zero_threshold(zero_threshold)
    );
    vstac_far_model far (.sys_clk, .avs_waitrequest, .avs_readdata, .bias_graphics_sel, .avs_req, .cmd_primary,
        .cmd_graphics, .adc_valid, .adc_data);
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic xfer(input logic [7:0] a, input logic we, input logic [31:0] wd);
        bit ok;
        far.access(a, we, wd, rv, ok);
        if (!ok) begin
            num_errors++;
            stop_test();
        end
    endtask
    task automatic wait_level(input bit gfx, input logic [7:0] code);
        for (int n = 0; n < 1000; n++) begin
            @(posedge sys_clk);
            if ((gfx ? target_voltage_code_graphics : target_voltage_code_primary) === code) return;
        end
        num_errors++;
        stop_test();
    endtask
    task automatic settle(input logic [7:0] t);
        @(posedge sys_clk);
        far.temp_p <= t;
        repeat (300) @(posedge sys_clk);
        #1;
    endtask
    initial begin
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b1;
        xfer(8'h88, 1'b0, 32'h0); check("ctrl", rv, 32'h1);
        xfer(8'h8c, 1'b1, 32'h3f);
        xfer(8'h8c, 1'b0, 32'h0); check("thresh", rv, 32'h20);
        xfer(8'h48, 1'b0, 32'h0); check("zone rst", rv, 32'h0);
        xfer(8'h04, 1'b0, 32'h0); check("unmapped", rv, 32'h0);
        $display("registers done");
        far.cmd(1'b0, 2'h1, 8'h05); check("cc fast", continuous_conduction_primary, 1);
        wait_level(1'b0, 8'h05);
        repeat (2) @(posedge sys_clk);
        #1 check("alert fast", alert_n_oe, 1);
        xfer(8'h40, 1'b0, 32'h0); check("settled", rv[0], 1);
        #1 check("released", alert_n_oe, 0);
        far.cmd(1'b1, 2'h1, 8'h03);
        wait_level(1'b1, 8'h03);
        xfer(8'h40, 1'b0, 32'h0);
        far.cmd(1'b0, 2'h3, 8'h00); check("de", diode_emulation_primary, 1);
        repeat (12) @(posedge sys_clk);
        far.cmd(1'b0, 2'h2, 8'h08); check("preempt", alert_n_oe, 1);
        check("cc slow", continuous_conduction_primary, 1);
        xfer(8'h40, 1'b0, 32'h0);
        wait_level(1'b0, 8'h08);
        repeat (2) @(posedge sys_clk);
        #1 check("alert slow", alert_n_oe, 1);
        xfer(8'h40, 1'b0, 32'h0);
        far.cmd(1'b0, 2'h3, 8'h06);
        wait_level(1'b0, 8'h06);
        repeat (3) @(posedge sys_clk);
        #1 check("no decay alert", alert_n_oe, 0);
        $display("ramps done");
        settle(8'h9a); check("warm alert", alert_n_oe, 1);
        xfer(8'h40, 1'b0, 32'h0); check("therm set", rv[1], 1);
        #1 check("released", alert_n_oe, 0);
        xfer(8'h48, 1'b0, 32'h0); check("zone 7f", rv, 32'h7f);
        settle(8'h90); check("hot", thermal_throttle_n, 0);
        xfer(8'h48, 1'b0, 32'h0); check("zone ff", rv, 32'hff);
        settle(8'h9a); check("hot hold", thermal_throttle_n, 0);
        settle(8'ha4); check("cool", thermal_throttle_n, 1);
        check("quiet", alert_n_oe, 0);
        settle(8'ha5); check("cool alert", alert_n_oe, 1);
        xfer(8'h40, 1'b0, 32'h0); check("therm clr", rv[1], 0);
        $display("thermal done");
        multi_phase <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 check("aux open", aux_switch_close, 0);
        check("aux track", aux_track_drive, 1);
        @(posedge sys_clk);
        discontinuous_conduction <= 1'b1;
        low_side_on_req <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1 check("ls on", low_side_gate, 1);
        @(posedge sys_clk);
        // Request stays up, so only the zero-cross can turn the gate off
        zero_cross_pin <= 1'b1;
        body_diode_pin <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 check("ls off", low_side_gate, 0);
        @(posedge sys_clk);
        zero_cross_pin <= 1'b0;
        body_diode_pin <= 1'b0;
        repeat (10) @(posedge sys_clk);
        #1 check("th step", zero_threshold, 6'h21);
        $display("switching done");
        stop_test();
    end
endmodule
